// ===== rtl/foc_vector_math_datapath.sv
// Rotation, sine lookup, ripple compensation and null-vector datapath
`timescale 1ns/1ps
`default_nettype none
module foc_vector_math_datapath
	import foc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Angle and rotation stage
	input wire logic rot_valid_i,
	input wire logic use_flux_angle_i,
	input wire logic [ANGLE_W-1:0] electrical_angle_code_i,
	input wire logic signed [DATA_W-1:0] flux_alpha_i,
	input wire logic signed [DATA_W-1:0] flux_beta_i,
	input wire logic signed [DATA_W-1:0] flux_mag_i,
	input wire logic signed [DATA_W-1:0] i_alpha_i,
	input wire logic signed [DATA_W-1:0] i_beta_i,
	input wire logic signed [DATA_W-1:0] v_d_i,
	input wire logic signed [DATA_W-1:0] v_q_i,
	output logic signed [DATA_W-1:0] sin_o,
	output logic signed [DATA_W-1:0] cos_o,
	output logic signed [DATA_W-1:0] i_d_o,
	output logic signed [DATA_W-1:0] i_q_o,
	output logic signed [DATA_W-1:0] v_alpha_o,
	output logic signed [DATA_W-1:0] v_beta_o,
	output logic rot_done_o,
	// Ripple compensation stage
	input wire logic comp_valid_i,
	input wire logic signed [DATA_W-1:0] ripple_k_i,
	input wire logic signed [DATA_W-1:0] dc_bus_i,
	input wire logic signed [DATA_W-1:0] u_alpha_i,
	input wire logic signed [DATA_W-1:0] u_beta_i,
	output logic signed [DATA_W-1:0] duty_alpha_o,
	output logic signed [DATA_W-1:0] duty_beta_o,
	output logic comp_done_o,
	// Null vector selection
	input wire logic null_valid_i,
	input wire logic [2:0] sector_i,
	output logic [2:0] null_state_o,
	output logic null_done_o,
	// Three PI loops
	input wire logic [2:0] pi_valid_i,
	input wire logic signed [3*DATA_W-1:0] pi_ref_i,
	input wire logic signed [3*DATA_W-1:0] pi_fb_i,
	input wire logic signed [3*DATA_W-1:0] pi_kp_i,
	input wire logic signed [3*DATA_W-1:0] pi_ki_i,
	input wire logic signed [3*DATA_W-1:0] pi_kc_i,
	input wire logic signed [3*DATA_W-1:0] pi_umax_i,
	input wire logic signed [3*DATA_W-1:0] pi_umin_i,
	output logic signed [3*DATA_W-1:0] pi_u_o,
	output logic [2:0] pi_done_o
);
	function automatic logic signed [DATA_W-1:0] sat(input logic signed [PROD_W:0] v);
		if (v > PROD_W'(FRAC_MAX))
			return FRAC_MAX;
		else if (v < $signed((PROD_W+1)'(FRAC_MIN)))
			return FRAC_MIN;
		else
			return v[DATA_W-1:0];
	endfunction : sat

	function automatic logic signed [DATA_W-1:0] fmul(input logic signed [DATA_W-1:0] a,
		input logic signed [DATA_W-1:0] b);
		logic signed [PROD_W-1:0] p;
		p = a * b;
		return sat((PROD_W+1)'(p >>> FRAC_SHIFT));
	endfunction : fmul

	function automatic logic signed [DATA_W-1:0] fadd(input logic signed [DATA_W-1:0] a,
		input logic signed [DATA_W-1:0] b);
		return sat((PROD_W+1)'(a) + (PROD_W+1)'(b));
	endfunction : fadd

	function automatic logic signed [DATA_W-1:0] fsub(input logic signed [DATA_W-1:0] a,
		input logic signed [DATA_W-1:0] b);
		return sat((PROD_W+1)'(a) - (PROD_W+1)'(b));
	endfunction : fsub

	function automatic logic [DATA_W:0] beta_abs_in(input logic signed [DATA_W-1:0] v);
		return v[DATA_W-1] ? (DATA_W+1)'(-v) : (DATA_W+1)'(v);
	endfunction : beta_abs_in

	// Reset synchroniser
	logic rst_s1_q;
	logic rst_s2_q;
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= 1'b1;
		end
		else
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire logic rst = rst_s2_q;

	// Rotation sequencer: table read takes one cycle, divider sixteen
	typedef enum logic [2:0] {ROT_IDLE, ROT_LOOKUP, ROT_DIVIDE, ROT_ROTATE} rot_state_e;
	rot_state_e rot_state_q;
	rot_state_e rot_state_d;

	wire logic [ANGLE_W-1:0] cos_angle = electrical_angle_code_i + QUARTER_TURN;
	wire logic [TABLE_AW-1:0] sin_addr = electrical_angle_code_i[ANGLE_W-1:TABLE_SHIFT];
	wire logic [TABLE_AW-1:0] cos_addr = cos_angle[ANGLE_W-1:TABLE_SHIFT];
	logic signed [DATA_W-1:0] tab_sin;
	logic signed [DATA_W-1:0] tab_cos;

	sine_lookup_table u_table (
		.ref_clk_i(ref_clk_i),
		.addr_a_i(sin_addr),
		.addr_b_i(cos_addr),
		.data_a_o(tab_sin),
		.data_b_o(tab_cos)
	);

	// Operands latched at the strobe so callers may change them afterwards
	logic signed [DATA_W-1:0] ia_q, ib_q, vd_q, vq_q, fa_q, fb_q, fm_q;

	// Restoring division of |num| by |mag|, both fractions, result Q15
	logic [DATA_W:0] rem_s_q, rem_c_q;
	logic [DATA_W-1:0] quo_s_q, quo_c_q;
	logic [4:0] step_q;
	wire logic [DATA_W-1:0] mag_abs = fm_q[DATA_W-1] ? DATA_W'(-fm_q) : fm_q;
	// First step is unshifted: it gives the integer bit, so the quotient is Q15
	wire logic first_div = step_q == 5'h00;
	wire logic [DATA_W:0] rs_sh = first_div ? rem_s_q : {rem_s_q[DATA_W-1:0], 1'b0};
	wire logic [DATA_W:0] rc_sh = first_div ? rem_c_q : {rem_c_q[DATA_W-1:0], 1'b0};
	wire logic s_ge = rs_sh >= {1'b0, mag_abs};
	wire logic c_ge = rc_sh >= {1'b0, mag_abs};
	wire logic [DATA_W-1:0] quo_s_nx = {quo_s_q[DATA_W-2:0], s_ge};
	wire logic [DATA_W-1:0] quo_c_nx = {quo_c_q[DATA_W-2:0], c_ge};
	// Limitation: |flux| must not exceed magnitude; quotient saturates to 1.0
	wire logic signed [DATA_W-1:0] fsin_mag = quo_s_nx[DATA_W-1] ? FRAC_MAX : quo_s_nx;
	wire logic signed [DATA_W-1:0] fcos_mag = quo_c_nx[DATA_W-1] ? FRAC_MAX : quo_c_nx;
	wire logic signed [DATA_W-1:0] flux_sin = fb_q[DATA_W-1] ? -fsin_mag : fsin_mag;
	wire logic signed [DATA_W-1:0] flux_cos = fa_q[DATA_W-1] ? -fcos_mag : fcos_mag;
	logic signed [DATA_W-1:0] sn_q, cs_q;

	wire logic signed [DATA_W-1:0] d_fwd = fadd(fmul(cs_q, ia_q), fmul(sn_q, ib_q));
	wire logic signed [DATA_W-1:0] q_fwd = fsub(fmul(cs_q, ib_q), fmul(sn_q, ia_q));
	wire logic signed [DATA_W-1:0] a_inv = fsub(fmul(cs_q, vd_q), fmul(sn_q, vq_q));
	wire logic signed [DATA_W-1:0] b_inv = fadd(fmul(sn_q, vd_q), fmul(cs_q, vq_q));

	always_comb
	begin
		rot_state_d = rot_state_q;
		unique case (rot_state_q)
			ROT_IDLE: if (rot_valid_i) rot_state_d = use_flux_angle_i ? ROT_DIVIDE : ROT_LOOKUP;
			ROT_LOOKUP: rot_state_d = ROT_ROTATE;
			ROT_DIVIDE: if (step_q == 5'(DIV_STEPS - 1)) rot_state_d = ROT_ROTATE;
			ROT_ROTATE: rot_state_d = ROT_IDLE;
			default: rot_state_d = ROT_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst)
		begin
			rot_state_q <= ROT_IDLE;
			{ia_q, ib_q, vd_q, vq_q, fa_q, fb_q, fm_q} <= '0;
			{rem_s_q, rem_c_q, quo_s_q, quo_c_q, step_q} <= '0;
			{sn_q, cs_q} <= '0;
		end
		else
		begin
			rot_state_q <= rot_state_d;
			if (rot_state_q == ROT_IDLE && rot_valid_i)
			begin
				{ia_q, ib_q, vd_q, vq_q} <= {i_alpha_i, i_beta_i, v_d_i, v_q_i};
				{fa_q, fb_q, fm_q} <= {flux_alpha_i, flux_beta_i, flux_mag_i};
				rem_s_q <= beta_abs_in(flux_beta_i);
				rem_c_q <= beta_abs_in(flux_alpha_i);
				step_q <= '0;
			end
			if (rot_state_q == ROT_LOOKUP)
			begin
				sn_q <= tab_sin;
				cs_q <= tab_cos;
			end
			if (rot_state_q == ROT_DIVIDE)
			begin
				rem_s_q <= s_ge ? rs_sh - {1'b0, mag_abs} : rs_sh;
				rem_c_q <= c_ge ? rc_sh - {1'b0, mag_abs} : rc_sh;
				quo_s_q <= {quo_s_q[DATA_W-2:0], s_ge};
				quo_c_q <= {quo_c_q[DATA_W-2:0], c_ge};
				step_q <= step_q + 5'h01;
				if (step_q == 5'(DIV_STEPS - 1))
				begin
					sn_q <= flux_sin;
					cs_q <= flux_cos;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst)
		begin
			{sin_o, cos_o, i_d_o, i_q_o, v_alpha_o, v_beta_o} <= '0;
			rot_done_o <= 1'b0;
		end
		else
		begin
			rot_done_o <= (rot_state_q == ROT_ROTATE);
			if (rot_state_q == ROT_ROTATE)
			begin
				{sin_o, cos_o} <= {sn_q, cs_q};
				{i_d_o, i_q_o} <= {d_fwd, q_fwd};
				{v_alpha_o, v_beta_o} <= {a_inv, b_inv};
			end
		end
	end

	// Ripple compensation: one product check, then a sixteen-step divide by the bus
	wire logic signed [DATA_W-1:0] k_eff = (ripple_k_i > 16'sh0000) ? ripple_k_i : RIPPLE_K_SVM;
	logic signed [DATA_W-1:0] pa_q, pb_q, bus_q;
	logic sat_a_q, sat_b_q, neg_a_q, neg_b_q;
	logic [DATA_W:0] ra_q, rb_q;
	logic [DATA_W-1:0] qa_q, qb_q;
	logic [4:0] cstep_q;
	logic comp_busy_q;
	wire logic signed [DATA_W-1:0] prod_a = fmul(k_eff, u_alpha_i);
	wire logic signed [DATA_W-1:0] prod_b = fmul(k_eff, u_beta_i);
	wire logic [DATA_W:0] half_bus = (DATA_W+1)'(dc_bus_i) >> 1;
	wire logic [DATA_W:0] pa_abs = beta_abs_in(prod_a);
	wire logic [DATA_W:0] pb_abs = beta_abs_in(prod_b);
	wire logic [DATA_W-1:0] bus_abs = bus_q;
	wire logic [DATA_W:0] ra_sh = (cstep_q == 5'h00) ? ra_q : {ra_q[DATA_W-1:0], 1'b0};
	wire logic [DATA_W:0] rb_sh = (cstep_q == 5'h00) ? rb_q : {rb_q[DATA_W-1:0], 1'b0};
	wire logic a_ge = ra_sh >= {1'b0, bus_abs};
	wire logic b_ge = rb_sh >= {1'b0, bus_abs};
	// Bus at or below zero is meaningless; treat as saturated to avoid a zero divide
	wire logic bus_bad = dc_bus_i <= 16'sh0000;
	wire logic signed [DATA_W-1:0] sign_a = neg_a_q ? ONE_NEG : ONE_POS;
	wire logic signed [DATA_W-1:0] sign_b = neg_b_q ? ONE_NEG : ONE_POS;
	wire logic signed [DATA_W-1:0] qa_s = qa_q[DATA_W-1] ? FRAC_MAX : qa_q;
	wire logic signed [DATA_W-1:0] qb_s = qb_q[DATA_W-1] ? FRAC_MAX : qb_q;
	wire logic signed [DATA_W-1:0] res_a = sat_a_q ? sign_a : (neg_a_q ? -qa_s : qa_s);
	wire logic signed [DATA_W-1:0] res_b = sat_b_q ? sign_b : (neg_b_q ? -qb_s : qb_s);

	always_ff @(posedge ref_clk_i)
	begin
		if (rst)
		begin
			{pa_q, pb_q, bus_q, ra_q, rb_q, qa_q, qb_q, cstep_q} <= '0;
			{sat_a_q, sat_b_q, neg_a_q, neg_b_q, comp_busy_q} <= '0;
			{duty_alpha_o, duty_beta_o} <= '0;
			comp_done_o <= 1'b0;
		end
		else
		begin
			comp_done_o <= 1'b0;
			if (!comp_busy_q && comp_valid_i)
			begin
				comp_busy_q <= 1'b1;
				cstep_q <= '0;
				bus_q <= dc_bus_i;
				ra_q <= pa_abs;
				rb_q <= pb_abs;
				neg_a_q <= u_alpha_i[DATA_W-1];
				neg_b_q <= u_beta_i[DATA_W-1];
				sat_a_q <= bus_bad || !(pa_abs < half_bus);
				sat_b_q <= bus_bad || !(pb_abs < half_bus);
			end
			else if (comp_busy_q)
			begin
				ra_q <= a_ge ? ra_sh - {1'b0, bus_abs} : ra_sh;
				rb_q <= b_ge ? rb_sh - {1'b0, bus_abs} : rb_sh;
				qa_q <= {qa_q[DATA_W-2:0], a_ge};
				qb_q <= {qb_q[DATA_W-2:0], b_ge};
				cstep_q <= cstep_q + 5'h01;
				if (cstep_q == 5'(DIV_STEPS))
				begin
					comp_busy_q <= 1'b0;
					comp_done_o <= 1'b1;
					duty_alpha_o <= res_a;
					duty_beta_o <= res_b;
				end
			end
		end
	end

	// Null vector: alternating zero state keeps switching symmetric about the centre
	wire logic [2:0] null_pick = sector_i[0] ? NULL_ALL_HIGH : NULL_ALL_LOW;
	always_ff @(posedge ref_clk_i)
	begin
		if (rst)
		begin
			null_state_o <= NULL_ALL_LOW;
			null_done_o <= 1'b0;
		end
		else
		begin
			null_done_o <= null_valid_i;
			if (null_valid_i)
				null_state_o <= null_pick;
		end
	end

	// Loops: index follows loop_sel_e; the improved form covers basic and incremental forms
	for (genvar g = 0; g < 3; g++)
	begin : g_pi
		pi_regulator u_pi (
			.ref_clk_i(ref_clk_i),
			.rst_i(rst),
			.valid_i(pi_valid_i[g]),
			.ref_i(pi_ref_i[g*DATA_W +: DATA_W]),
			.fb_i(pi_fb_i[g*DATA_W +: DATA_W]),
			.kp_i(pi_kp_i[g*DATA_W +: DATA_W]),
			.ki_i(pi_ki_i[g*DATA_W +: DATA_W]),
			.kc_i(pi_kc_i[g*DATA_W +: DATA_W]),
			.umax_i(pi_umax_i[g*DATA_W +: DATA_W]),
			.umin_i(pi_umin_i[g*DATA_W +: DATA_W]),
			.u_o(pi_u_o[g*DATA_W +: DATA_W]),
			.done_o(pi_done_o[g])
		);
	end
endmodule : foc_vector_math_datapath
`default_nettype wire

// ===== rtl/foc_pkg.sv
// Shared constants for the field-oriented-control vector datapath
package foc_pkg;
	localparam int DATA_W = 16;
	localparam int ANGLE_W = 12;
	localparam int TABLE_AW = 8;
	localparam int TABLE_DEPTH = 256;
	localparam int TABLE_SHIFT = 4;
	localparam int PROD_W = 32;
	localparam int FRAC_SHIFT = 15;
	localparam logic [11:0] QUARTER_TURN = 12'h400;
	localparam logic signed [15:0] FRAC_MAX = 16'sh7fff;
	localparam logic signed [15:0] FRAC_MIN = -16'sh7fff - 16'sh0001;
	localparam logic signed [15:0] ONE_POS = 16'sh7fff;
	localparam logic signed [15:0] ONE_NEG = -16'sh7fff - 16'sh0001;
	localparam logic signed [15:0] RIPPLE_K_SVM = 16'sh6ed9;
	localparam logic [2:0] NULL_ALL_LOW = 3'h0;
	localparam logic [2:0] NULL_ALL_HIGH = 3'h7;
	localparam int DIV_STEPS = 16;
	typedef enum logic [1:0] {PI_SPEED, PI_CURRENT, PI_POSITION} loop_sel_e;
endpackage : foc_pkg

// ===== rtl/sine_lookup_table.sv
// Quarter-wave-free full-turn sine table with registered read data
`timescale 1ns/1ps
`default_nettype none
module sine_lookup_table
	import foc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [TABLE_AW-1:0] addr_a_i,
	input wire logic [TABLE_AW-1:0] addr_b_i,
	output logic signed [DATA_W-1:0] data_a_o,
	output logic signed [DATA_W-1:0] data_b_o
);
	logic signed [DATA_W-1:0] rom [TABLE_DEPTH];

	// Table built at elaboration; no file read, so it synthesises as a ROM
	initial
	begin
		for (int i = 0; i < TABLE_DEPTH; i++)
		begin
			rom[i] = DATA_W'($rtoi(32767.0 * $sin(6.283185307179586 * i / TABLE_DEPTH)));
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		data_a_o <= rom[addr_a_i];
		data_b_o <= rom[addr_b_i];
	end
endmodule : sine_lookup_table
`default_nettype wire

// ===== rtl/pi_regulator.sv
// Clamped PI regulator with integral back-calculation
`timescale 1ns/1ps
`default_nettype none
module pi_regulator
	import foc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic valid_i,
	input wire logic signed [DATA_W-1:0] ref_i,
	input wire logic signed [DATA_W-1:0] fb_i,
	input wire logic signed [DATA_W-1:0] kp_i,
	input wire logic signed [DATA_W-1:0] ki_i,
	input wire logic signed [DATA_W-1:0] kc_i,
	input wire logic signed [DATA_W-1:0] umax_i,
	input wire logic signed [DATA_W-1:0] umin_i,
	output logic signed [DATA_W-1:0] u_o,
	output logic done_o
);
	function automatic logic signed [DATA_W-1:0] sat(input logic signed [PROD_W:0] v);
		if (v > PROD_W'(FRAC_MAX))
			return FRAC_MAX;
		else if (v < $signed((PROD_W+1)'(FRAC_MIN)))
			return FRAC_MIN;
		else
			return v[DATA_W-1:0];
	endfunction : sat

	function automatic logic signed [DATA_W-1:0] fmul(input logic signed [DATA_W-1:0] a,
		input logic signed [DATA_W-1:0] b);
		logic signed [PROD_W-1:0] p;
		p = a * b;
		return sat((PROD_W+1)'(p >>> FRAC_SHIFT));
	endfunction : fmul

	logic signed [DATA_W-1:0] x_q;
	logic signed [DATA_W-1:0] x_d;
	wire logic signed [DATA_W-1:0] err = sat((PROD_W+1)'(ref_i) - (PROD_W+1)'(fb_i));
	wire logic signed [DATA_W-1:0] u_raw = sat((PROD_W+1)'(x_q) + (PROD_W+1)'(fmul(kp_i, err)));
	wire logic signed [DATA_W-1:0] u_clamp = (u_raw > umax_i) ? umax_i :
		(u_raw < umin_i) ? umin_i : u_raw;
	wire logic signed [DATA_W-1:0] diff = sat((PROD_W+1)'(u_clamp) - (PROD_W+1)'(u_raw));
	// Back-calculation bleeds the integrator when clamped, so it cannot wind up
	assign x_d = sat((PROD_W+1)'(x_q) + (PROD_W+1)'(fmul(ki_i, err))
		+ (PROD_W+1)'(fmul(kc_i, diff)));

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			x_q <= '0;
			u_o <= '0;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= valid_i;
			if (valid_i)
			begin
				x_q <= x_d;
				u_o <= u_clamp;
			end
		end
	end
endmodule : pi_regulator
`default_nettype wire

// ===== verification/foc_datapath_props.sv
// Port-level concurrent checks for the vector math datapath
`timescale 1ns/1ps
`default_nettype none
module foc_datapath_props
	import foc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic rot_valid_i,
	input wire logic use_flux_angle_i,
	input wire logic [ANGLE_W-1:0] electrical_angle_code_i,
	input wire logic signed [DATA_W-1:0] sin_o,
	input wire logic signed [DATA_W-1:0] cos_o,
	input wire logic rot_done_o,
	input wire logic comp_valid_i,
	input wire logic comp_done_o,
	input wire logic signed [DATA_W-1:0] duty_alpha_o,
	input wire logic null_valid_i,
	input wire logic [2:0] sector_i,
	input wire logic [2:0] null_state_o,
	input wire logic null_done_o,
	input wire logic [2:0] pi_valid_i,
	input wire logic signed [3*DATA_W-1:0] pi_umax_i,
	input wire logic signed [3*DATA_W-1:0] pi_umin_i,
	input wire logic signed [3*DATA_W-1:0] pi_u_o,
	input wire logic [2:0] pi_done_o
);
	wire logic signed [DATA_W-1:0] lane_u = pi_u_o[31:16];
	wire logic signed [DATA_W-1:0] lane_hi = pi_umax_i[31:16];
	wire logic signed [DATA_W-1:0] lane_lo = pi_umin_i[31:16];
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_even_take; null_valid_i && !sector_i[0]; endsequence
	sequence s_odd_take; null_valid_i && sector_i[0]; endsequence
	sequence s_low_angle_take;
		rot_valid_i && !use_flux_angle_i && electrical_angle_code_i < 12'h010;
	endsequence
	a_null_even_low:
		assert property (s_even_take |=> null_done_o && null_state_o == NULL_ALL_LOW)
		else $error("even sector null not all-low");
	a_null_odd_high:
		assert property (s_odd_take |=> null_done_o && null_state_o == NULL_ALL_HIGH)
		else $error("odd sector null not all-high");
	a_table_quarter_turn:
		assert property (s_low_angle_take |-> ##3 (rot_done_o && sin_o == 16'sh0000
			&& cos_o == ONE_POS))
		else $error("zero angle sine or cosine wrong");
	a_rot_done_cause:
		assert property (rot_done_o |-> $past(rot_valid_i, 3) || $past(rot_valid_i, 18))
		else $error("rotation done without request");
	a_rot_result_hold:
		assert property ($changed(sin_o) |-> rot_done_o)
		else $error("sine moved outside done");
	a_comp_latency:
		assert property (comp_done_o |-> $past(comp_valid_i, 18))
		else $error("compensation done at wrong cycle");
	a_duty_hold:
		assert property ($changed(duty_alpha_o) |-> comp_done_o)
		else $error("duty moved outside done");
	a_null_done_cause:
		assert property (null_done_o |-> $past(null_valid_i))
		else $error("null done without request");
	a_pi_done_next:
		assert property (pi_done_o == $past(pi_valid_i))
		else $error("regulator done not one cycle after valid");
	a_pi_clamp_lane:
		assert property (pi_done_o[1] |-> lane_u <= $past(lane_hi) && lane_u >= $past(lane_lo))
		else $error("regulator output outside limits");
endmodule : foc_datapath_props
bind foc_vector_math_datapath foc_datapath_props u_props (.ref_clk_i, .nrst_i, .rot_valid_i,
	.use_flux_angle_i, .electrical_angle_code_i, .sin_o, .cos_o, .rot_done_o, .comp_valid_i,
	.comp_done_o, .duty_alpha_o, .null_valid_i, .sector_i, .null_state_o, .null_done_o,
	.pi_valid_i, .pi_umax_i, .pi_umin_i, .pi_u_o, .pi_done_o);
`default_nettype wire

// ===== verification/pwm_center_model.sv
// Center-aligned PWM unit fed with compensated duty ratios
`timescale 1ns/1ps
`default_nettype none
module pwm_center_model
	import foc_pkg::*;
#(
	parameter int HALF = 64
)
(
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic signed [DATA_W-1:0] duty_a_i,
	input wire logic signed [DATA_W-1:0] duty_b_i,
	output logic pwm_a_o,
	output logic pwm_b_o
);
	int cnt_q;
	int thr_a_q;
	int thr_b_q;
	logic up_q;
	// Thresholds reload only at the valley so each pulse stays symmetric
	always_ff @(posedge ref_clk_i or negedge nrst_i)
		if (!nrst_i)
		begin
			cnt_q <= 0;
			up_q <= 1'b1;
			thr_a_q <= 0;
			thr_b_q <= 0;
		end
		else
		begin
			cnt_q <= up_q ? cnt_q + 1 : cnt_q - 1;
			up_q <= (cnt_q == HALF - 1) ? 1'b0 : ((cnt_q == 1 && !up_q) ? 1'b1 : up_q);
			if (cnt_q == 0)
			begin
				thr_a_q <= (int'(duty_a_i) + 32'sh8000) * HALF / 32'sh10000;
				thr_b_q <= (int'(duty_b_i) + 32'sh8000) * HALF / 32'sh10000;
			end
		end
	assign pwm_a_o = cnt_q < thr_a_q;
	assign pwm_b_o = cnt_q < thr_b_q;
endmodule : pwm_center_model
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the vector math datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, t) begin samples_checked++; \
	if ($isunknown(g) || int'(g) - (e) > (t) || (e) - int'(g) > (t)) begin n_errors++; \
	$display("ERROR %0t got %h exp %h", $time, g, (e)); end end
module tb_top
	import foc_pkg::*;
;
	typedef struct {int kind; int v[6]; int t0; int t;} note_s;
	localparam int ONE = 32'sh8000;
	localparam int KP = 32'sh4000;
	localparam int KI = 32'sh0800;
	localparam int KC = 32'sh1000;
	localparam int HI = 32'sh1000;
	localparam int LO = -32'sh1000;
	note_s q[$];
	int n_errors = 0;
	int samples_checked = 0;
	int x[3] = '{0, 0, 0};
	logic ref_clk_i = 1'b0, nrst_i = 1'b0, rot_valid_i = 1'b0, use_flux_angle_i = 1'b0;
	logic comp_valid_i = 1'b0, null_valid_i = 1'b0, rot_done_o, comp_done_o, null_done_o;
	logic [11:0] electrical_angle_code_i = 12'h000;
	logic [2:0] sector_i = 3'h0, pi_valid_i = 3'h0, null_state_o, pi_done_o;
	logic signed [15:0] flux_alpha_i = '0, flux_beta_i = '0, flux_mag_i = 16'sh4000;
	logic signed [15:0] i_alpha_i = '0, i_beta_i = '0, v_d_i = '0, v_q_i = '0, ripple_k_i = '0;
	logic signed [15:0] dc_bus_i = 16'sh4000, u_alpha_i = '0, u_beta_i = '0;
	logic signed [15:0] sin_o, cos_o, i_d_o, i_q_o, v_alpha_o, v_beta_o, duty_alpha_o, duty_beta_o;
	logic signed [47:0] pi_ref_i = '0, pi_fb_i = '0, pi_kp_i = '0, pi_ki_i = '0, pi_kc_i = '0;
	logic signed [47:0] pi_umax_i = '0, pi_umin_i = '0, pi_u_o;
	foc_vector_math_datapath DUT (.ref_clk_i, .nrst_i, .rot_valid_i, .use_flux_angle_i,
		.electrical_angle_code_i, .flux_alpha_i, .flux_beta_i, .flux_mag_i, .i_alpha_i, .i_beta_i,
		.v_d_i, .v_q_i, .sin_o, .cos_o, .i_d_o, .i_q_o, .v_alpha_o, .v_beta_o, .rot_done_o,
		.comp_valid_i, .ripple_k_i, .dc_bus_i, .u_alpha_i, .u_beta_i, .duty_alpha_o, .duty_beta_o,
		.comp_done_o, .null_valid_i, .sector_i, .null_state_o, .null_done_o, .pi_valid_i,
		.pi_ref_i, .pi_fb_i, .pi_kp_i, .pi_ki_i, .pi_kc_i, .pi_umax_i, .pi_umin_i, .pi_u_o,
		.pi_done_o);
	pwm_center_model u_pwm (.ref_clk_i, .nrst_i, .duty_a_i(duty_alpha_o),
		.duty_b_i(duty_beta_o), .pwm_a_o(), .pwm_b_o());
	always #2.5 ref_clk_i = ~ref_clk_i;
	function automatic int sat(longint v);
		return v > FRAC_MAX ? FRAC_MAX : (v < FRAC_MIN ? FRAC_MIN : int'(v));
	endfunction : sat
	function automatic int mul(int a, int b);
		return sat(longint'(a) * b / ONE);
	endfunction : mul
	function automatic int tbl(int i);
		real v;
		v = 32767.0 * $sin(6.283185307179586 * i / 256.0);
		return $rtoi(v + (v > 0.0 ? 1.0e-6 : -1.0e-6));
	endfunction : tbl
	// Branch choice is made in real arithmetic, away from the bus/2 edge
	function automatic int rip(int k, int u, int bus);
		real p;
		p = real'(k <= 0 ? int'(RIPPLE_K_SVM) : k) * u / ONE;
		if (bus > 0 && p < bus / 2.0 && -p < bus / 2.0)
			return $rtoi(p * ONE / bus);
		return u >= 0 ? FRAC_MAX : FRAC_MIN;
	endfunction : rip
	task automatic step;
		@(posedge ref_clk_i);
		#1;
	endtask : step
	task automatic fire(input int k);
		int i;
		step;
		case (k)
			0: rot_valid_i = 1'b1;
			1: comp_valid_i = 1'b1;
			default: pi_valid_i[k-10] = 1'b1;
		endcase
		step;
		{rot_valid_i, comp_valid_i, pi_valid_i} = '0;
		for (i = 0; i < 30 && !(rot_done_o | comp_done_o | (|pi_done_o)); i++)
			step;
		if (i == 30)
			n_errors++;
	endtask : fire
	task automatic rot(input logic [11:0] a, input logic fl, input int fa, input int fb, input int fm);
		int s, c;
		note_s n;
		electrical_angle_code_i = a;
		use_flux_angle_i = fl;
		{flux_alpha_i, flux_beta_i, flux_mag_i} = {16'(fa), 16'(fb), 16'(fm)};
		{i_alpha_i, i_beta_i, v_d_i, v_q_i} = {$urandom, $urandom};
		s = fl ? sat(fb * ONE / fm) : tbl(a[11:4]);
		c = fl ? sat(fa * ONE / fm) : tbl(8'(a[11:4] + 8'h40));
		n.kind = 0;
		n.v[0] = s;
		n.v[1] = c;
		n.v[2] = sat((longint'(c) * i_alpha_i + longint'(s) * i_beta_i) / ONE);
		n.v[3] = sat((longint'(c) * i_beta_i - longint'(s) * i_alpha_i) / ONE);
		n.v[4] = sat((longint'(c) * v_d_i - longint'(s) * v_q_i) / ONE);
		n.v[5] = sat((longint'(s) * v_d_i + longint'(c) * v_q_i) / ONE);
		n.t0 = fl ? 1 : 0;
		n.t = fl ? 4 : 3;
		q.push_back(n);
		fire(0);
	endtask : rot
	task automatic pi(input int g, input int r, input int f);
		int e, u, uc;
		note_s n;
		pi_ref_i[g*16 +: 16] = 16'(r);
		pi_fb_i[g*16 +: 16] = 16'(f);
		e = sat(r - f);
		u = sat(x[g] + mul(KP, e));
		uc = u > HI ? HI : (u < LO ? LO : u);
		x[g] = sat(x[g] + mul(KI, e) + mul(KC, sat(uc - u)));
		n.kind = 10 + g;
		n.v[0] = uc;
		n.t = 12;
		q.push_back(n);
		fire(10 + g);
	endtask : pi
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	always @(negedge ref_clk_i)
		if (rot_done_o | comp_done_o | null_done_o | (|pi_done_o))
		begin
			note_s n;
			if (q.size() == 0)
				n_errors++;
			else
			begin
				n = q.pop_front();
				if (n.kind == 0)
				begin
					`CHK(sin_o, n.v[0], n.t0)
					`CHK(cos_o, n.v[1], n.t0)
					`CHK(i_d_o, n.v[2], n.t)
					`CHK(i_q_o, n.v[3], n.t)
					`CHK(v_alpha_o, n.v[4], n.t)
					`CHK(v_beta_o, n.v[5], n.t)
				end
				else if (n.kind == 1)
				begin
					`CHK(duty_alpha_o, n.v[0], 3)
					`CHK(duty_beta_o, n.v[1], 3)
				end
				else if (n.kind == 2)
					`CHK(null_state_o, n.v[0], 0)
				else
					`CHK($signed(pi_u_o[(n.kind-10)*16 +: 16]), n.v[0], n.t)
			end
		end
	initial
	begin
		#50us;
		n_errors++;
		tally_and_finish;
	end
	initial
	begin
		static logic [11:0] ang[6] = '{12'h000, 12'h00f, 12'h3ff, 12'h400, 12'hc00, 12'hfff};
		static int ct[4][4] = '{'{0, 32'sh1000, -32'sh1000, 32'sh4000}, '{32'sh4000, 32'sh2000,
			-32'sh2000, 32'sh4000}, '{0, 32'sh7000, -32'sh7000, 32'sh2000}, '{32'sh2000, 0, -1, 0}};
		note_s n;
		void'($urandom(58));
		repeat (10) @(posedge ref_clk_i);
		#1 nrst_i = 1'b1;
		repeat (3) step;
		foreach (ang[i])
			rot(ang[i], 1'b0, 0, 0, 32'sh4000);
		for (int i = 0; i < 6; i++)
			rot(12'($urandom), 1'b0, 0, 0, 32'sh4000);
		rot(12'h123, 1'b1, 32'sh3000, 32'sh4000, 32'sh5000);
		rot(12'h000, 1'b1, 32'sh6000, -32'sh7000, 32'sh5000);
		$display("rotation test done");
		foreach (ct[i])
		begin
			{ripple_k_i, u_alpha_i, u_beta_i, dc_bus_i} = {16'(ct[i][0]), 16'(ct[i][1]),
				16'(ct[i][2]), 16'(ct[i][3])};
			n.kind = 1;
			n.v[0] = rip(ct[i][0], ct[i][1], ct[i][3]);
			n.v[1] = rip(ct[i][0], ct[i][2], ct[i][3]);
			q.push_back(n);
			fire(1);
		end
		$display("compensation test done");
		// Back-to-back requests: one sector per cycle
		for (int s = 0; s < 8; s++)
		begin
			n.kind = 2;
			n.v[0] = s[0] ? 7 : 0;
			q.push_back(n);
			null_valid_i = 1'b1;
			sector_i = 3'(s);
			step;
		end
		null_valid_i = 1'b0;
		$display("null vector test done");
		{pi_kp_i, pi_ki_i, pi_kc_i} = {{3{16'(KP)}}, {3{16'(KI)}}, {3{16'(KC)}}};
		{pi_umax_i, pi_umin_i} = {{3{16'(HI)}}, {3{16'(LO)}}};
		for (int g = 0; g < 3; g++)
			for (int k = 0; k < 5; k++)
				pi(g, int'($signed(14'($urandom))), int'($signed(14'($urandom))));
		$display("regulator test done");
		repeat (5) step;
		if (q.size() != 0)
			n_errors++;
		tally_and_finish;
	end
endmodule : tb_top
`default_nettype wire
